/* File: src/rhp_pkg.sv */
// Shared constants and types for the host register group of the node controller.
// Assumes a 200 MHz system clock and a classic Wishbone slave with 32-bit data.
`default_nettype none
package rhp_pkg;
  localparam int          CLK_PERIOD_NS  = 5;
  // Byte offsets on the register bus
  localparam logic [7:0]  OFS_PTR_HIGH   = 8'h00;
  localparam logic [7:0]  OFS_PTR_LOW    = 8'h04;
  localparam logic [7:0]  OFS_SEL        = 8'h08;
  localparam logic [7:0]  OFS_CFG        = 8'h0c;
  localparam logic [7:0]  OFS_DATA       = 8'h10;
  localparam logic [7:0]  OFS_WINDOW     = 8'h14;
  localparam logic [7:0]  OFS_STATUS     = 8'h18;
  localparam logic [7:0]  OFS_DIAG       = 8'h1c;
  localparam logic [7:0]  OFS_RESP_CYC   = 8'h20;
  localparam logic [7:0]  OFS_IDLE_CYC   = 8'h24;
  localparam logic [7:0]  OFS_RECON_CYC  = 8'h28;
  // Field positions
  localparam int          PH_DIR_BIT     = 7;
  localparam int          PH_STEP_BIT    = 6;
  localparam int          CFG_RESET_BIT  = 7;
  localparam int          CFG_CHAIN_BIT  = 6;
  localparam int          CFG_TRANSMIT_PERMIT_BIT   = 5;
  localparam int          CFG_ET1_BIT    = 4;
  localparam int          CFG_ET2_BIT    = 3;
  localparam int          CFG_BKPL_BIT   = 2;
  // Indirect selector codes
  localparam logic [2:0]  SEL_TENT_ID    = 3'h0;
  localparam logic [2:0]  SEL_NODE_ID    = 3'h1;
  localparam logic [2:0]  SEL_SETUP_ONE  = 3'h2;
  localparam logic [2:0]  SEL_NEXT_ID    = 3'h3;
  localparam logic [2:0]  SEL_SETUP_TWO  = 3'h4;
  // Reset values
  localparam logic [7:0]  CFG_RST        = 8'h00;
  localparam logic [7:0]  BYTE_RST       = 8'h00;
  localparam logic [2:0]  SEL_RST        = 3'h0;
  localparam logic [10:0] PTR_RST        = 11'h000;
  // Network times per extended-timeout code, at 5 Mbps with reconfiguration timer 00
  localparam int unsigned RESP_NS  [4]   = '{596600, 298400, 149200, 37400};
  localparam int unsigned IDLE_NS  [4]   = '{656000, 328000, 164000, 41000};
  localparam int unsigned RECON_NS [4]   = '{840000000, 840000000, 840000000, 420000000};

  typedef struct packed {
    logic        re;
    logic        we;
    logic [10:0] addr;
    logic [7:0]  wdata;
  } rhp_ram_req_t;

  typedef struct packed {
    logic [31:0] resp;
    logic [31:0] idle;
    logic [31:0] recon;
  } rhp_times_t;

  typedef enum logic [1:0] {ST_IDLE, ST_RAM_RD, ST_RD_WAIT, ST_DONE} rhp_bus_state_t;
endpackage : rhp_pkg
`default_nettype wire

/* File: src/rhp_ptr.sv */
// Eleven-bit buffer RAM address pointer with byte loads and a carrying step.
// Loads and steps come from one bus access at a time, so they never coincide.
`default_nettype none
module rhp_ptr #(
  parameter int ADDR_W = 11
) (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Control
  input  wire logic              load_low_i,
  input  wire logic              load_high_i,
  input  wire logic [7:0]        wdata_i,
  input  wire logic              step_i,
  // Address
  output logic      [ADDR_W-1:0] addr_o
);
  import rhp_pkg::*;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      addr_o <= ADDR_W'(PTR_RST);
    end else if (load_high_i) begin
      addr_o[ADDR_W-1:8] <= wdata_i[ADDR_W-9:0];
    end else if (load_low_i) begin
      addr_o[7:0] <= wdata_i;
    end else if (step_i) begin
      addr_o <= addr_o + ADDR_W'(1);
    end
  end

  a_step_carry: assert property (@(posedge clk_i) disable iff (rst_i)
    step_i && !load_low_i && !load_high_i && addr_o[7:0] == 8'hff
    |=> addr_o[ADDR_W-1:8] == $past(addr_o[ADDR_W-1:8]) + 1'b1)
    else $error("pointer step did not carry into the upper bits");
endmodule : rhp_ptr
`default_nettype wire

/* File: src/rhp_tmo.sv */
// Response, idle and reconfiguration times in clock cycles for the selected timeout code.
// SCALE_DIV only shortens the counts for simulation; keep it at 1 in silicon.
`default_nettype none
module rhp_tmo #(
  parameter int unsigned SCALE_DIV = 1
) (
  // Clock and reset
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  // Selection
  input  wire logic [1:0]          long_timeout_sel_i,
  input  wire logic [1:0]          reconfig_timer_sel_i,
  // Times
  output rhp_pkg::rhp_times_t      times_o
);
  import rhp_pkg::*;

  function automatic logic [31:0] to_cyc(input int unsigned ns);
    int unsigned c;
    c = ns / CLK_PERIOD_NS / SCALE_DIV;
    to_cyc = (c == 0) ? 32'h0000_0001 : 32'(c);
  endfunction : to_cyc

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      times_o <= '0;
    end else begin
      times_o.resp  <= to_cyc(RESP_NS[long_timeout_sel_i]);
      times_o.idle  <= to_cyc(IDLE_NS[long_timeout_sel_i]);
      // Each reconfiguration-timer step doubles the base; the table only covers code 00
      times_o.recon <= to_cyc(RECON_NS[long_timeout_sel_i]) << reconfig_timer_sel_i;
    end
  end

  a_recon_timer: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 $stable(long_timeout_sel_i) && reconfig_timer_sel_i == 2'h1
    |=> times_o.recon == 2 * to_cyc(RECON_NS[$past(long_timeout_sel_i)]))
    else $error("reconfiguration time ignores the timer selection");
  a_fast_code: assert property (@(posedge clk_i) disable iff (rst_i)
    long_timeout_sel_i == 2'h3 |=> times_o.idle == to_cyc(IDLE_NS[3]))
    else $error("idle time wrong for fastest timeout code");
endmodule : rhp_tmo
`default_nettype wire

/* File: src/rhp_host_regs.sv */
// Host register group: RAM pointer, indirect selector, node configuration, window and status.
// Classic Wishbone slave, 8-bit registers in the low byte of aligned words and 32-bit cycle-count registers; sync RAM outside.
`default_nettype none
module rhp_host_regs #(
  parameter int unsigned TMO_SCALE_DIV = 1
) (
  // Clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  // Wishbone slave
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [7:0]           wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic      [31:0]          wb_dat_o,
  output logic                      wb_ack_o,
  // Buffer RAM port
  output rhp_pkg::rhp_ram_req_t     ram_req_o,
  input  wire logic [7:0]           ram_rdata_i,
  // Protocol engine side
  input  wire logic [7:0]           engine_status_i,
  input  wire logic [7:0]           engine_diag_i,
  input  wire logic [7:0]           engine_next_id_i,
  input  wire logic                 pulse_a_req_i,
  input  wire logic                 pulse_b_req_i,
  input  wire logic                 line_drive_req_i,
  // Node configuration outputs
  output logic                      soft_reset_o,
  output logic                      chaining_on_o,
  output logic                      backplane_o,
  output logic      [7:0]           node_id_o,
  output logic      [7:0]           tentative_id_o,
  output logic      [7:0]           setup_one_o,
  output logic      [7:0]           setup_two_o,
  output rhp_pkg::rhp_times_t       times_o,
  // Media pins
  output logic                      media_pulse_out_a_n_o,
  output logic                      media_pulse_out_b_n_o,
  output logic                      line_driver_enable_n_o
);
  import rhp_pkg::*;

  rhp_bus_state_t state_q;
  logic           access_direction_read_q;
  logic           pointer_auto_step_q;
  logic [1:0]     sel_lo_q;
  logic           sel_hi_q;
  logic [7:0]     cfg_q;
  logic [7:0]     status_q;
  logic [7:0]     diag_q;
  logic [7:0]     next_id_q;
  logic [10:0]    ram_addr;
  logic [2:0]     indirect_selector;
  logic           acc;
  logic           wr;
  logic           data_wr;
  logic           data_rd;
  logic           step;
  logic [7:0]     wbyte;
  logic [7:0]     window_rd;
  logic [31:0]    rd_mux;

  assign indirect_selector = {sel_hi_q, sel_lo_q};
  assign acc     = wb_cyc_i && wb_stb_i && state_q == ST_IDLE;
  assign wr      = acc && wb_we_i && wb_sel_i[0];
  assign wbyte   = wb_dat_i[7:0];
  assign data_wr = wr && wb_adr_i == OFS_DATA && !access_direction_read_q;
  assign data_rd = acc && !wb_we_i && wb_adr_i == OFS_DATA && access_direction_read_q;
  // Read steps once its data is taken; write steps as it is issued
  assign step    = pointer_auto_step_q && (data_wr || state_q == ST_RD_WAIT);

  rhp_ptr #(
    .ADDR_W      (11)
  ) u_ptr (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .load_low_i  (wr && wb_adr_i == OFS_PTR_LOW),
    .load_high_i (wr && wb_adr_i == OFS_PTR_HIGH),
    .wdata_i     (wbyte),
    .step_i      (step),
    .addr_o      (ram_addr)
  );

  rhp_tmo #(
    .SCALE_DIV            (TMO_SCALE_DIV)
  ) u_tmo (
    .clk_i                (clk_i),
    .rst_i                (rst_i),
    .long_timeout_sel_i   ({cfg_q[CFG_ET1_BIT], cfg_q[CFG_ET2_BIT]}),
    .reconfig_timer_sel_i (setup_one_o[1:0]),
    .times_o              (times_o)
  );

  // Pointer-high control bits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      access_direction_read_q <= 1'b0;
      pointer_auto_step_q     <= 1'b0;
    end else if (wr && wb_adr_i == OFS_PTR_HIGH) begin
      access_direction_read_q <= wbyte[PH_DIR_BIT];
      pointer_auto_step_q     <= wbyte[PH_STEP_BIT];
    end
  end

  // Selector store shared by two registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {sel_hi_q, sel_lo_q} <= SEL_RST;
    end else if (wr && wb_adr_i == OFS_SEL) begin
      {sel_hi_q, sel_lo_q} <= wbyte[2:0];
    end else if (wr && wb_adr_i == OFS_CFG) begin
      sel_lo_q <= wbyte[1:0];
      sel_hi_q <= 1'b0;
    end
  end

  // Configuration bits 7..2; bits 1..0 live in the selector store
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_q <= CFG_RST;
    end else if (wr && wb_adr_i == OFS_CFG) begin
      cfg_q <= {wbyte[7:2], 2'b00};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      soft_reset_o  <= 1'b0;
      chaining_on_o <= 1'b0;
      backplane_o   <= 1'b0;
    end else begin
      soft_reset_o  <= cfg_q[CFG_RESET_BIT];
      chaining_on_o <= cfg_q[CFG_CHAIN_BIT];
      backplane_o   <= cfg_q[CFG_BKPL_BIT];
    end
  end

  // Window registers; writes to next ID and reserved codes are dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tentative_id_o <= BYTE_RST;
      node_id_o      <= BYTE_RST;
      setup_one_o    <= BYTE_RST;
      setup_two_o    <= BYTE_RST;
    end else if (wr && wb_adr_i == OFS_WINDOW) begin
      case (indirect_selector)
        SEL_TENT_ID:   tentative_id_o <= wbyte;
        SEL_NODE_ID:   node_id_o      <= wbyte;
        SEL_SETUP_ONE: setup_one_o    <= wbyte;
        SEL_SETUP_TWO: setup_two_o    <= wbyte;
        default: ;
      endcase
    end
  end

  // Engine-owned registers are held cleared while the soft reset bit stays one
  always_ff @(posedge clk_i) begin
    if (rst_i || cfg_q[CFG_RESET_BIT]) begin
      status_q  <= BYTE_RST;
      diag_q    <= BYTE_RST;
      next_id_q <= BYTE_RST;
    end else begin
      status_q  <= engine_status_i;
      diag_q    <= engine_diag_i;
      next_id_q <= engine_next_id_i;
    end
  end

  // Media pins are active low; pulse B is left to the engine in backplane mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      media_pulse_out_a_n_o  <= 1'b1;
      media_pulse_out_b_n_o  <= 1'b1;
      line_driver_enable_n_o <= 1'b1;
    end else begin
      media_pulse_out_a_n_o  <= !(pulse_a_req_i && cfg_q[CFG_TRANSMIT_PERMIT_BIT]);
      media_pulse_out_b_n_o  <= !(pulse_b_req_i && (cfg_q[CFG_TRANSMIT_PERMIT_BIT] || cfg_q[CFG_BKPL_BIT]));
      line_driver_enable_n_o <= !(line_drive_req_i && cfg_q[CFG_TRANSMIT_PERMIT_BIT]);
    end
  end

  always_comb begin
    case (indirect_selector)
      SEL_TENT_ID:   window_rd = tentative_id_o;
      SEL_NODE_ID:   window_rd = node_id_o;
      SEL_SETUP_ONE: window_rd = setup_one_o;
      SEL_NEXT_ID:   window_rd = next_id_q;
      SEL_SETUP_TWO: window_rd = setup_two_o;
      default:       window_rd = 8'h00;
    endcase
  end

  // Reserved and unmapped bits read as zero
  always_comb begin
    case (wb_adr_i)
      OFS_PTR_HIGH:  rd_mux = {24'h0, access_direction_read_q, pointer_auto_step_q, 3'b000, ram_addr[10:8]};
      OFS_PTR_LOW:   rd_mux = {24'h0, ram_addr[7:0]};
      OFS_SEL:       rd_mux = {29'h0, indirect_selector};
      OFS_CFG:       rd_mux = {24'h0, cfg_q[7:2], sel_lo_q};
      OFS_WINDOW:    rd_mux = {24'h0, window_rd};
      OFS_STATUS:    rd_mux = {24'h0, status_q};
      OFS_DIAG:      rd_mux = {24'h0, diag_q};
      OFS_RESP_CYC:  rd_mux = times_o.resp;
      OFS_IDLE_CYC:  rd_mux = times_o.idle;
      OFS_RECON_CYC: rd_mux = times_o.recon;
      default:       rd_mux = 32'h0000_0000;
    endcase
  end

  // Bus sequencing; data reads wait for the RAM's one-cycle latency
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q  <= ST_IDLE;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (data_rd) begin
            state_q <= ST_RAM_RD;
          end else if (acc) begin
            state_q  <= ST_DONE;
            wb_ack_o <= 1'b1;
            wb_dat_o <= wb_we_i ? 32'h0000_0000 : rd_mux;
          end
        end
        ST_RAM_RD: state_q <= ST_RD_WAIT;
        ST_RD_WAIT: begin
          state_q  <= ST_DONE;
          wb_ack_o <= 1'b1;
          wb_dat_o <= {24'h0, ram_rdata_i};
        end
        ST_DONE: begin
          state_q  <= ST_IDLE;
          wb_ack_o <= 1'b0;
        end
        default: begin
          state_q  <= ST_IDLE;
          wb_ack_o <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ram_req_o <= '0;
    end else begin
      ram_req_o.re    <= data_rd;
      ram_req_o.we    <= data_wr;
      ram_req_o.addr  <= ram_addr;
      ram_req_o.wdata <= wbyte;
    end
  end

  a_read_direction: assert property (@(posedge clk_i) disable iff (rst_i)
    ram_req_o.re |-> access_direction_read_q && state_q == ST_RAM_RD)
    else $error("RAM read issued without read direction");
  a_write_direction: assert property (@(posedge clk_i) disable iff (rst_i)
    acc && wb_we_i && wb_sel_i[0] && wb_adr_i == OFS_DATA && access_direction_read_q
    |=> !ram_req_o.we)
    else $error("RAM written while direction is read");
  a_read_data_taken: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == ST_RD_WAIT
    |=> wb_ack_o && wb_dat_o[7:0] == $past(ram_rdata_i))
    else $error("data read did not return the RAM byte");
  a_step_write: assert property (@(posedge clk_i) disable iff (rst_i)
    data_wr && pointer_auto_step_q |=> ram_addr == $past(ram_addr) + 11'h001)
    else $error("pointer did not step after data write");
  a_step_read: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == ST_RD_WAIT && pointer_auto_step_q
    |=> ram_addr == $past(ram_addr) + 11'h001)
    else $error("pointer did not step after data read");
  a_hold_pointer: assert property (@(posedge clk_i) disable iff (rst_i)
    data_rd && !pointer_auto_step_q |=> ##2 ram_addr == $past(ram_addr, 3))
    else $error("pointer moved with stepping off");
  a_load_upper: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && wb_adr_i == OFS_PTR_HIGH |=> ram_addr[10:8] == $past(wbyte[2:0]))
    else $error("upper address bits not loaded");
  a_load_lower: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && wb_adr_i == OFS_PTR_LOW |=> ram_addr[7:0] == $past(wbyte))
    else $error("lower address bits not loaded");
  a_window_next_id: assert property (@(posedge clk_i) disable iff (rst_i)
    acc && !wb_we_i && wb_adr_i == OFS_WINDOW && indirect_selector == SEL_NEXT_ID
    |=> wb_ack_o && wb_dat_o[7:0] == $past(next_id_q))
    else $error("window did not return next ID");
  a_window_drop: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && wb_adr_i == OFS_WINDOW && (indirect_selector == SEL_NEXT_ID || indirect_selector > SEL_SETUP_TWO)
    |=> $stable(tentative_id_o) && $stable(node_id_o) && $stable(setup_one_o) && $stable(setup_two_o))
    else $error("window write to a read-only or reserved code took effect");
  a_shared_selector: assert property (@(posedge clk_i) disable iff (rst_i)
    acc && !wb_we_i && wb_adr_i == OFS_CFG
    |=> wb_dat_o[1:0] == $past(indirect_selector[1:0]))
    else $error("selector low bits not shared with configuration");
  a_cfg_clears_top: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && wb_adr_i == OFS_CFG |=> !sel_hi_q)
    else $error("configuration write left top selector bit set");
  a_soft_reset_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    cfg_q[CFG_RESET_BIT] [*2] |-> status_q == 8'h00 && next_id_q == 8'h00 && diag_q == 8'h00)
    else $error("engine registers not held in soft reset");
  a_soft_reset_out: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && wb_adr_i == OFS_CFG
    |=> ##1 soft_reset_o == $past(wbyte[CFG_RESET_BIT], 2))
    else $error("soft reset output does not follow the written bit");
  a_chain_output: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && wb_adr_i == OFS_CFG
    |=> ##1 chaining_on_o == $past(wbyte[CFG_CHAIN_BIT], 2))
    else $error("chaining output does not follow the written bit");
  a_tx_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    !cfg_q[CFG_TRANSMIT_PERMIT_BIT] |=> line_driver_enable_n_o && media_pulse_out_a_n_o)
    else $error("media outputs active with transmit permit low");
  a_pulse_b_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    !cfg_q[CFG_TRANSMIT_PERMIT_BIT] && !cfg_q[CFG_BKPL_BIT] |=> media_pulse_out_b_n_o)
    else $error("pulse B active outside backplane with transmit permit low");
  a_backplane_output: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && wb_adr_i == OFS_CFG
    |=> ##1 backplane_o == $past(wbyte[CFG_BKPL_BIT], 2))
    else $error("backplane output does not follow the written bit");
  a_reserved_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    acc && !wb_we_i && (wb_adr_i == OFS_PTR_HIGH || wb_adr_i == OFS_SEL)
    |=> wb_dat_o[5:3] == 3'b000)
    else $error("reserved bits read back nonzero");
  a_ram_write_addr: assert property (@(posedge clk_i) disable iff (rst_i)
    data_wr
    |=> ram_req_o.we && ram_req_o.addr == $past(ram_addr) && ram_req_o.wdata == $past(wbyte))
    else $error("RAM write not issued at the pointer address");
  a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge held for more than one cycle");
endmodule : rhp_host_regs
`default_nettype wire

/* File: bench/rhp_ram_model.sv */
// Behavioural 2K x 8 buffer RAM standing behind the host register group.
// Assumes the request struct of rhp_pkg and a one-cycle synchronous read.
`default_nettype none
module rhp_ram_model
  import rhp_pkg::*;
(
  // Clock
  input  wire logic         clk_i,
  // Request and data
  input  wire rhp_ram_req_t req_i,
  output logic      [7:0]   rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [2048];

  always_ff @(posedge clk_i) begin
    if (req_i.we) begin
      mem[req_i.addr] <= req_i.wdata;
    end
  end

  // Data toggles outside its valid cycle so a late sample cannot pass
  always_ff @(posedge clk_i) begin
    if (req_i.re) begin
      rdata_o <= mem[req_i.addr];
    end else begin
      rdata_o <= ~rdata_o;
    end
  end
endmodule : rhp_ram_model
`default_nettype wire

/* File: bench/test_rhp_host_regs.sv */
// Self-checking bench for the host register group and a behavioural buffer RAM.
// Classic Wishbone single cycles; network times shortened through TMO_SCALE_DIV.
`default_nettype none
module test_rhp_host_regs;
  timeunit 1ns;
  timeprecision 1ps;
  import rhp_pkg::*;
  localparam int unsigned DIV = 1000;
  typedef struct packed {logic chk; logic [31:0] exp;} rhp_note_t;
  logic         clk_i    = 1'b0;
  logic         rst_i    = 1'b1;
  logic         wb_cyc_i = 1'b0;
  logic         wb_stb_i = 1'b0;
  logic         wb_we_i  = 1'b0;
  logic [7:0]   wb_adr_i = 8'h00;
  logic [3:0]   wb_sel_i = 4'h0;
  logic [31:0]  wb_dat_i = 32'h0;
  logic [7:0]   status   = 8'h00;
  logic [7:0]   diag     = 8'h00;
  logic [7:0]   next_id  = 8'h00;
  logic         pa_req   = 1'b0;
  logic         pb_req   = 1'b0;
  logic         ld_req   = 1'b0;
  logic [3:0]   lane     = 4'h1;
  logic [31:0]  wb_dat_o;
  logic         wb_ack_o;
  rhp_ram_req_t ram_req;
  logic [7:0]   ram_rdata;
  logic         soft_reset, chaining_on, backplane, pa_n, pb_n, ld_n;
  logic [7:0]   node_id, tent_id, setup_one, setup_two, d0, d1;
  logic [7:0]   v [6];
  rhp_times_t   times;
  rhp_note_t    note;
  rhp_note_t    notes [$];
  int           num_errors = 0;
  int           num_checks = 0;
  int           seed       = 35;

  always #2.5 clk_i = ~clk_i;

  rhp_host_regs #(.TMO_SCALE_DIV(DIV)) rhp_host_regs_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .ram_req_o(ram_req), .ram_rdata_i(ram_rdata), .engine_status_i(status),
    .engine_diag_i(diag), .engine_next_id_i(next_id), .pulse_a_req_i(pa_req), .pulse_b_req_i(pb_req),
    .line_drive_req_i(ld_req), .soft_reset_o(soft_reset), .chaining_on_o(chaining_on),
    .backplane_o(backplane), .node_id_o(node_id), .tentative_id_o(tent_id), .setup_one_o(setup_one),
    .setup_two_o(setup_two), .times_o(times), .media_pulse_out_a_n_o(pa_n),
    .media_pulse_out_b_n_o(pb_n), .line_driver_enable_n_o(ld_n));

  rhp_ram_model rhp_ram_model_i (.clk_i(clk_i), .req_i(ram_req), .rdata_o(ram_rdata));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim

  // Request held until ack is sampled, then one idle cycle before the next
  task automatic bus(input logic we, input logic [7:0] adr, input logic [7:0] dat,
                     input logic chk, input logic [31:0] exp);
    int n;
    notes.push_back('{chk, exp});
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_sel_i <= lane;
    wb_dat_i <= {24'h0, dat};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (wb_ack_o !== 1'b1) begin
      num_errors++;
      end_sim();
    end
  endtask : bus

  task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
    bus(1'b1, adr, dat, 1'b0, 32'h0);
  endtask : wr

  task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
    bus(1'b0, adr, 8'h00, 1'b1, exp);
  endtask : rd

  // Pairs every ack with the oldest note; data is checked for reads only
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1) begin
      if (notes.size() == 0) begin
        check("spare ack", 32'h1, 32'h0);
      end else begin
        note = notes.pop_front();
        if (note.chk) begin
          check("read data", wb_dat_o, note.exp);
        end
      end
    end
  end

  initial begin
    repeat (20) @(posedge clk_i);
    rst_i   <= 1'b0;
    status  <= 8'($random(seed));
    diag    <= 8'($random(seed));
    next_id <= 8'($random(seed));
    d0 = 8'($random(seed));
    d1 = 8'($random(seed));
    rd(OFS_CFG, 32'h0);
    check("pulse a idle", 32'(pa_n), 32'h1);
    wr(OFS_PTR_LOW, 8'hff);
    wr(OFS_PTR_HIGH, 8'h42);
    rd(OFS_DATA, 32'h0);
    wr(OFS_DATA, d0);
    wr(OFS_DATA, d1);
    rd(OFS_PTR_LOW, 32'h01);
    rd(OFS_PTR_HIGH, 32'h43);
    wr(OFS_PTR_LOW, 8'hff);
    wr(OFS_PTR_HIGH, 8'hc2);
    wr(OFS_DATA, ~d0);
    rd(OFS_DATA, 32'(d0));
    rd(OFS_DATA, 32'(d1));
    wr(OFS_PTR_LOW, 8'hff);
    wr(OFS_PTR_HIGH, 8'h82);
    rd(OFS_DATA, 32'(d0));
    rd(OFS_DATA, 32'(d0));
    for (int c = 0; c < 6; c++) begin
      v[c] = 8'($random(seed));
      wr(OFS_SEL, 8'(c));
      wr(OFS_WINDOW, v[c]);
      rd(OFS_WINDOW, 32'((c == 3) ? next_id : (c == 5) ? 8'h00 : v[c]));
    end
    check("tentative id", 32'(tent_id), 32'(v[0]));
    check("node id", 32'(node_id), 32'(v[1]));
    check("setup two", 32'(setup_two), 32'(v[4]));
    wr(OFS_SEL, 8'h04);
    wr(OFS_CFG, 8'h01);
    rd(OFS_SEL, 32'h01);
    wr(OFS_SEL, 8'h06);
    rd(OFS_CFG, 32'h02);
    rd(OFS_STATUS, 32'(status));
    wr(OFS_CFG, 8'h83);
    @(posedge clk_i);
    check("soft reset", 32'(soft_reset), 32'h1);
    rd(OFS_STATUS, 32'h0);
    rd(OFS_DIAG, 32'h0);
    rd(OFS_WINDOW, 32'h0);
    rd(OFS_CFG, 32'h83);
    wr(OFS_CFG, 8'h00);
    rd(OFS_DIAG, 32'(diag));
    check("soft reset off", 32'(soft_reset), 32'h0);
    wr(OFS_CFG, 8'h44);
    pa_req <= 1'b1;
    pb_req <= 1'b1;
    ld_req <= 1'b1;
    repeat (2) @(posedge clk_i);
    check("chaining", 32'(chaining_on), 32'h1);
    check("backplane", 32'(backplane), 32'h1);
    check("pulse a held", 32'(pa_n), 32'h1);
    check("driver held", 32'(ld_n), 32'h1);
    check("pulse b backplane", 32'(pb_n), 32'h0);
    wr(OFS_CFG, 8'h20);
    repeat (2) @(posedge clk_i);
    check("pulse a active", 32'(pa_n), 32'h0);
    check("pulse b active", 32'(pb_n), 32'h0);
    check("driver active", 32'(ld_n), 32'h0);
    check("chaining off", 32'(chaining_on), 32'h0);
    wr(OFS_SEL, 8'h02);
    wr(OFS_WINDOW, 8'h00);
    for (int c = 0; c < 4; c++) begin
      wr(OFS_CFG, 8'(c << 3));
      rd(OFS_RESP_CYC, RESP_NS[c] / CLK_PERIOD_NS / DIV);
      rd(OFS_IDLE_CYC, IDLE_NS[c] / CLK_PERIOD_NS / DIV);
      rd(OFS_RECON_CYC, RECON_NS[c] / CLK_PERIOD_NS / DIV);
    end
    check("idle time out", times.idle, IDLE_NS[3] / CLK_PERIOD_NS / DIV);
    wr(OFS_SEL, 8'h02);
    wr(OFS_WINDOW, 8'h01);
    rd(OFS_RECON_CYC, (RECON_NS[3] / CLK_PERIOD_NS / DIV) << 1);
    check("setup one", 32'(setup_one), 32'h01);
    check("recon time out", times.recon, (RECON_NS[3] / CLK_PERIOD_NS / DIV) << 1);
    wr(8'h30, 8'h12);
    rd(8'h30, 32'h0);
    lane = 4'h0;
    wr(OFS_PTR_LOW, 8'h55);
    lane = 4'h1;
    rd(OFS_PTR_LOW, 32'hff);
    end_sim();
  end
endmodule : test_rhp_host_regs
`default_nettype wire
